/* File: hw/msfm_top.sv */
// top of the motor servo fault monitor for paper feed and carriage axes
// assumes encoder and drive flags arrive asynchronously as pins
`timescale 1ns/1ns
module msfm_top #(
  parameter int SETTLE_US      = msfm_pkg::SETTLE_US,
  parameter int ENC_TIMEOUT_US = 2000,
  parameter int PULSE_MAX_US   = 1000
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        PF_RUN,
  input  wire logic        PF_INIT_CHECK,
  input  wire logic        PF_STOP,
  input  wire logic        PF_ENC_A,
  input  wire logic        PF_ENC_B,
  input  wire logic [15:0] PF_FOLLOW_ERR,
  input  wire logic [15:0] PF_OOS_LIMIT,
  input  wire logic [15:0] PF_POS_ERR,
  input  wire logic        PF_OVC,
  input  wire logic        PF_DEMAND_HI,
  input  wire logic        CR_RUN,
  input  wire logic        CR_INIT_CHECK,
  input  wire logic        CR_STOP,
  input  wire logic        CR_ENC_A,
  input  wire logic        CR_ENC_B,
  input  wire logic [15:0] CR_FOLLOW_ERR,
  input  wire logic [15:0] CR_OOS_LIMIT,
  input  wire logic [15:0] CR_POS_ERR,
  input  wire logic        CR_OVC,
  input  wire logic        CR_DEMAND_HI,
  output logic [31:0]      FAULT_CODE,
  output logic             FAULT,
  output logic             MOTION_ENABLE
);
  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_q;
  logic       rst_n;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) rst_q <= 2'b00;
    else       rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // three stages; a change counts once stages two and three agree
  logic [5:0] s1_q, s2_q, s3_q, lv_q, lv_d;
  logic [5:0] raw;
  assign raw = {PF_ENC_A, PF_ENC_B, PF_OVC, CR_ENC_A, CR_ENC_B, CR_OVC};
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      lv_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lv_q[i];
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lv_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lv_q <= lv_d;
    end
  end

  // ****************************************
  // 1 us tick and encoder edges
  // ****************************************
  logic [4:0] div_q, div_d;
  logic       tick;
  logic [5:0] lv_prev_q;
  logic       pf_edge, cr_edge;
  always_comb begin
    tick  = (div_q == 5'(msfm_pkg::TICK_CYC - 1));
    div_d = tick ? 5'h00 : div_q + 5'h01;
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= 5'h00;
      lv_prev_q <= '0;
    end else begin
      div_q     <= div_d;
      lv_prev_q <= lv_q;
    end
  end
  assign pf_edge = (lv_q[5:4] != lv_prev_q[5:4]);
  assign cr_edge = (lv_q[2:1] != lv_prev_q[2:1]);

  // ****************************************
  // axis supervisors
  // ****************************************
  logic pf_enc, pf_oos, pf_ovc, pf_inp;
  logic cr_enc, cr_oos, cr_ovc, cr_inp;

  msfm_axis #(
    .ENC_TIMEOUT_US (ENC_TIMEOUT_US),
    .PULSE_MAX_US   (PULSE_MAX_US),
    .SETTLE_US      (SETTLE_US)
  ) u_pf (
    .clk         (CLK),
    .rst_n       (rst_n),
    .tick        (tick),
    .active      (PF_RUN),
    .checking    (PF_INIT_CHECK),
    .stop_req    (PF_STOP),
    .enc_edge    (pf_edge),
    .enc_level_a (lv_q[5]),
    .follow_err  (PF_FOLLOW_ERR),
    .oos_limit   (PF_OOS_LIMIT),
    .pos_err     (PF_POS_ERR),
    .ovc_hw      (lv_q[3]),
    .demand_hi   (PF_DEMAND_HI),
    .f_enc       (pf_enc),
    .f_oos       (pf_oos),
    .f_ovc       (pf_ovc),
    .f_inp       (pf_inp)
  );

  msfm_axis #(
    .ENC_TIMEOUT_US (ENC_TIMEOUT_US),
    .PULSE_MAX_US   (PULSE_MAX_US),
    .SETTLE_US      (SETTLE_US)
  ) u_cr (
    .clk         (CLK),
    .rst_n       (rst_n),
    .tick        (tick),
    .active      (CR_RUN),
    .checking    (CR_INIT_CHECK),
    .stop_req    (CR_STOP),
    .enc_edge    (cr_edge),
    .enc_level_a (lv_q[2]),
    .follow_err  (CR_FOLLOW_ERR),
    .oos_limit   (CR_OOS_LIMIT),
    .pos_err     (CR_POS_ERR),
    .ovc_hw      (lv_q[0]),
    .demand_hi   (CR_DEMAND_HI),
    .f_enc       (cr_enc),
    .f_oos       (cr_oos),
    .f_ovc       (cr_ovc),
    .f_inp       (cr_inp)
  );

  // ****************************************
  // first-fault latch and motion stop
  // ****************************************
  logic [31:0] code_q, code_d;
  logic        hit_q, hit_d;
  always_comb begin
    code_d = code_q;
    hit_d  = hit_q;
    if (!hit_q) begin
      hit_d = 1'b1;
      if      (pf_enc) code_d = msfm_pkg::CODE_PF_ENC;
      else if (pf_oos) code_d = msfm_pkg::CODE_PF_OOS;
      else if (pf_ovc) code_d = msfm_pkg::CODE_PF_OVC;
      else if (pf_inp) code_d = msfm_pkg::CODE_PF_INP;
      else if (cr_enc) code_d = msfm_pkg::CODE_CR_ENC;
      else if (cr_oos) code_d = msfm_pkg::CODE_CR_OOS;
      else if (cr_ovc) code_d = msfm_pkg::CODE_CR_OVC;
      else if (cr_inp) code_d = msfm_pkg::CODE_CR_INP;
      else hit_d = 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      code_q        <= msfm_pkg::CODE_NONE;
      hit_q         <= 1'b0;
      FAULT_CODE    <= msfm_pkg::CODE_NONE;
      FAULT         <= 1'b0;
      MOTION_ENABLE <= 1'b0;
    end else begin
      code_q        <= code_d;
      hit_q         <= hit_d;
      FAULT_CODE    <= code_d;
      FAULT         <= hit_d;
      MOTION_ENABLE <= !hit_d;
    end
  end
endmodule : msfm_top

/* File: hw/msfm_pkg.sv */
// package for the motor servo fault monitor: fault codes, limits, timing counts
// assumes a 25 MHz system clock and one reset shared by the whole block
// Operation
// - paper feed encoder timeout or long pulse: 00010001
// - paper feed following error limit: out-of-step
// - paper feed overcurrent or demand excess: 00010002
// - paper feed not settled 4 s: 00010003
// - carriage encoder check failure: code 00010004
// - carriage timeout, long pulse, following error: 00010005
// - carriage overcurrent or demand excess: 00010006
// - carriage not settled 4 s: 00010007
// - publish code and stop all motion
// - paper feed encoder check failure: 00010000
package msfm_pkg;
  // ****************************************
  // fault codes
  // ****************************************
  localparam logic [31:0] CODE_NONE    = 32'h0000_0000;
  localparam logic [31:0] CODE_PF_ENC  = 32'h0001_0000;
  localparam logic [31:0] CODE_PF_OOS  = 32'h0001_0001;
  localparam logic [31:0] CODE_PF_OVC  = 32'h0001_0002;
  localparam logic [31:0] CODE_PF_INP  = 32'h0001_0003;
  localparam logic [31:0] CODE_CR_ENC  = 32'h0001_0004;
  localparam logic [31:0] CODE_CR_OOS  = 32'h0001_0005;
  localparam logic [31:0] CODE_CR_OVC  = 32'h0001_0006;
  localparam logic [31:0] CODE_CR_INP  = 32'h0001_0007;
  // ****************************************
  // timing and widths
  // ****************************************
  localparam int          CLK_HZ       = 25_000_000;
  localparam int          TICK_US      = 1;
  localparam int          TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          SETTLE_S     = 4;
  localparam int          SETTLE_US    = SETTLE_S * 1_000_000;
  localparam int          POS_W        = 16;
  localparam int          CNT_W        = 24;
  localparam logic [15:0] SETTLE_PULSE = 16'h0005;
endpackage : msfm_pkg

/* File: hw/msfm_axis.sv */
// one axis supervisor: encoder timing, following error, current, in-position
// assumes a one-cycle 1 us tick and synchronised quadrature edges
`timescale 1ns/1ns
module msfm_axis #(
  parameter int ENC_TIMEOUT_US = 2000,
  parameter int PULSE_MAX_US   = 1000,
  parameter int SETTLE_US      = msfm_pkg::SETTLE_US
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       tick,
  input  wire logic                       active,
  input  wire logic                       checking,
  input  wire logic                       stop_req,
  input  wire logic                       enc_edge,
  input  wire logic                       enc_level_a,
  input  wire logic [msfm_pkg::POS_W-1:0] follow_err,
  input  wire logic [msfm_pkg::POS_W-1:0] oos_limit,
  input  wire logic [msfm_pkg::POS_W-1:0] pos_err,
  input  wire logic                       ovc_hw,
  input  wire logic                       demand_hi,
  output logic                            f_enc,
  output logic                            f_oos,
  output logic                            f_ovc,
  output logic                            f_inp
);
  localparam int CNT_W = msfm_pkg::CNT_W;
  logic [msfm_pkg::CNT_W-1:0] gap_q, gap_d, wid_q, wid_d, set_q, set_d;
  logic                       settle_q, settle_d;
  logic                       prev_a_q;

  // counters of tick time since last edge, level time, settle time
  always_comb begin
    gap_d    = (enc_edge || !(active || checking)) ? '0 :
               (tick ? gap_q + 1'b1 : gap_q);
    wid_d    = (enc_level_a != prev_a_q || !active) ? '0 :
               (tick ? wid_q + 1'b1 : wid_q);
    settle_d = stop_req ? 1'b1 : ((pos_err < msfm_pkg::SETTLE_PULSE) ? 1'b0 : settle_q);
    set_d    = (!settle_q || stop_req) ? '0 : (tick ? set_q + 1'b1 : set_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q    <= '0;
      wid_q    <= '0;
      set_q    <= '0;
      settle_q <= 1'b0;
      prev_a_q <= 1'b0;
    end else begin
      gap_q    <= gap_d;
      wid_q    <= wid_d;
      set_q    <= set_d;
      settle_q <= settle_d;
      prev_a_q <= enc_level_a;
    end
  end

  // fault detection, one level per class
  always_comb begin
    f_enc = checking && (gap_q >= CNT_W'(ENC_TIMEOUT_US));
    f_oos = active && ((gap_q >= CNT_W'(ENC_TIMEOUT_US))
            || (wid_q >= CNT_W'(PULSE_MAX_US))
            || (follow_err >= oos_limit));
    f_ovc = (active || settle_q) && (ovc_hw || demand_hi);
    f_inp = settle_q && !f_oos && (set_q >= CNT_W'(SETTLE_US));
  end
endmodule : msfm_axis

/* File: tb/msfm_asserts.sv */
// checker for the fault monitor: fault latch, motion stop, response timing
// assumes binding to msfm_top, seeing only its ports
`timescale 1ns/1ns
module msfm_asserts (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        PF_RUN,
  input wire logic        CR_RUN,
  input wire logic        PF_DEMAND_HI,
  input wire logic        CR_DEMAND_HI,
  input wire logic [15:0] PF_FOLLOW_ERR,
  input wire logic [15:0] PF_OOS_LIMIT,
  input wire logic [15:0] CR_FOLLOW_ERR,
  input wire logic [15:0] CR_OOS_LIMIT,
  input wire logic [31:0] FAULT_CODE,
  input wire logic        FAULT,
  input wire logic        MOTION_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // latch, stop and code relations
  fault_hold_a: assert property (FAULT |=> FAULT) else $error("fault dropped");
  code_hold_a: assert property (FAULT |=> $stable(FAULT_CODE)) else $error("code moved");
  motion_off_a: assert property (FAULT |-> !MOTION_ENABLE) else $error("motion on");
  code_flag_a: assert property (FAULT == (FAULT_CODE != 32'h0)) else $error("code flag");
  // excess demand answers next cycle
  pf_demand_a: assert property (PF_RUN && PF_DEMAND_HI && !FAULT && PF_FOLLOW_ERR < PF_OOS_LIMIT
    |=> FAULT_CODE == msfm_pkg::CODE_PF_OVC) else $error("pf demand");
  cr_demand_a: assert property (!PF_RUN && CR_RUN && CR_DEMAND_HI && !FAULT
    && CR_FOLLOW_ERR < CR_OOS_LIMIT |=> FAULT_CODE == msfm_pkg::CODE_CR_OVC) else $error("cr dem");
  // following error at the limit
  pf_follow_a: assert property (PF_RUN && PF_FOLLOW_ERR >= PF_OOS_LIMIT && !FAULT
    |-> ##[1:3] FAULT_CODE == msfm_pkg::CODE_PF_OOS) else $error("pf follow");
  cr_follow_a: assert property (!PF_RUN && CR_RUN && CR_FOLLOW_ERR >= CR_OOS_LIMIT && !FAULT
    |-> ##[1:3] FAULT_CODE == msfm_pkg::CODE_CR_OOS) else $error("cr follow");
endmodule : msfm_asserts

bind msfm_top msfm_asserts u_chk (.*);

/* File: tb/msfm_motor.sv */
// one axis drive model: quadrature steps while running, overcurrent flag
// assumes the bench clock and an overcurrent command from the bench
`timescale 1ns/1ns
module msfm_motor (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic ovc_cmd,
  output logic      enc_a,
  output logic      enc_b,
  output logic      ovc
);
  logic [5:0] div_q = 6'h00;
  logic [1:0] ph_q  = 2'h0;
  // one step every 64 cycles while running, still otherwise
  always @(posedge clk) begin
    if (run) begin
      div_q <= div_q + 6'h01;
      if (div_q == 6'h3f) ph_q <= ph_q + 2'h1;
    end
  end
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  assign ovc   = ovc_cmd;
endmodule : msfm_motor

/* File: tb/tb_top.sv */
// bench for the fault monitor: one task per scenario, verdict at the end
// assumes two drive models and a shortened settle window of 50 us
`timescale 1ns/1ns
module tb_top;
  logic        CLK = 1'b0, NRST = 1'b0, PF_INIT_CHECK = 1'b0, CR_INIT_CHECK = 1'b0;
  logic        PF_RUN = 1'b0, PF_STOP = 1'b0, PF_DEMAND_HI = 1'b0, pf_oc = 1'b0;
  logic        CR_RUN = 1'b0, CR_STOP = 1'b0, CR_DEMAND_HI = 1'b0, cr_oc = 1'b0;
  logic [15:0] PF_FOLLOW_ERR = 16'h0, PF_POS_ERR = 16'h0, PF_OOS_LIMIT = 16'h0010;
  logic [15:0] CR_FOLLOW_ERR = 16'h0, CR_POS_ERR = 16'h0, CR_OOS_LIMIT = 16'h0010;
  logic        PF_ENC_A, PF_ENC_B, PF_OVC, CR_ENC_A, CR_ENC_B, CR_OVC, FAULT, MOTION_ENABLE;
  logic [31:0] FAULT_CODE;
  logic        pf_stall = 1'b0;
  int          n_fail = 0;
  int          comparisons = 0;
  initial forever #20 CLK = ~CLK;
  msfm_motor pf_m (.clk(CLK), .run(PF_RUN && !pf_stall), .ovc_cmd(pf_oc), .enc_a(PF_ENC_A),
    .enc_b(PF_ENC_B),
    .ovc(PF_OVC));
  msfm_motor cr_m (.clk(CLK), .run(CR_RUN), .ovc_cmd(cr_oc), .enc_a(CR_ENC_A), .enc_b(CR_ENC_B),
    .ovc(CR_OVC));
  msfm_top #(.SETTLE_US(50), .ENC_TIMEOUT_US(20), .PULSE_MAX_US(10)) uut (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // reset pulse and idle inputs, motion allowed afterwards
  task restart;
    @(posedge CLK);
    NRST <= 1'b0;
    {PF_RUN, PF_STOP, PF_DEMAND_HI, pf_oc, CR_RUN, CR_STOP, CR_DEMAND_HI, cr_oc} <= 8'h00;
    {PF_FOLLOW_ERR, PF_POS_ERR, CR_FOLLOW_ERR, CR_POS_ERR} <= 64'h0;
    {PF_INIT_CHECK, CR_INIT_CHECK, pf_stall} <= 3'h0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    repeat (6) @(posedge CLK);
    #1 chk(MOTION_ENABLE, 1);
    chk(FAULT_CODE, msfm_pkg::CODE_NONE);
    @(posedge CLK);
  endtask : restart
  // wait for the fault, then judge code and motion stop
  task done(input logic [31:0] exp);
    for (int i = 0; i < 3000 && FAULT !== 1'b1; i++) @(posedge CLK);
    #1 chk(FAULT_CODE, exp);
    chk(MOTION_ENABLE, 0);
  endtask : done
  task t_pf_dem;
    restart();
    PF_RUN <= 1'b1;
    PF_DEMAND_HI <= 1'b1;
    @(posedge CLK);
    PF_DEMAND_HI <= 1'b0;
    done(msfm_pkg::CODE_PF_OVC);
    CR_RUN <= 1'b1;
    CR_DEMAND_HI <= 1'b1;
    repeat (8) @(posedge CLK);
    chk(FAULT_CODE, msfm_pkg::CODE_PF_OVC);
  endtask : t_pf_dem
  task t_follow;
    restart();
    PF_RUN <= 1'b1;
    repeat (300) @(posedge CLK);
    chk(FAULT, 0);
    PF_FOLLOW_ERR <= 16'h0010;
    done(msfm_pkg::CODE_PF_OOS);
    restart();
    CR_RUN <= 1'b1;
    CR_FOLLOW_ERR <= 16'h0011;
    done(msfm_pkg::CODE_CR_OOS);
  endtask : t_follow
  task t_ovc;
    restart();
    PF_RUN <= 1'b1;
    pf_oc <= 1'b1;
    done(msfm_pkg::CODE_PF_OVC);
    restart();
    CR_RUN <= 1'b1;
    cr_oc <= 1'b1;
    done(msfm_pkg::CODE_CR_OVC);
    restart();
    CR_RUN <= 1'b1;
    CR_DEMAND_HI <= 1'b1;
    done(msfm_pkg::CODE_CR_OVC);
  endtask : t_ovc
  // encoder check windows and a stalled paper feed motor
  task t_enc;
    restart();
    PF_INIT_CHECK <= 1'b1;
    repeat (400) @(posedge CLK);
    chk(FAULT, 0);
    done(msfm_pkg::CODE_PF_ENC);
    restart();
    CR_INIT_CHECK <= 1'b1;
    done(msfm_pkg::CODE_CR_ENC);
    restart();
    PF_RUN <= 1'b1;
    pf_stall <= 1'b1;
    done(msfm_pkg::CODE_PF_OOS);
  endtask : t_enc
  // settle window: 50 us is 1250 cycles
  task t_settle;
    restart();
    PF_POS_ERR <= 16'h0008;
    PF_STOP <= 1'b1;
    @(posedge CLK);
    PF_STOP <= 1'b0;
    repeat (1000) @(posedge CLK);
    chk(FAULT, 0);
    done(msfm_pkg::CODE_PF_INP);
    restart();
    CR_POS_ERR <= 16'h0005;
    CR_STOP <= 1'b1;
    @(posedge CLK);
    CR_STOP <= 1'b0;
    done(msfm_pkg::CODE_CR_INP);
    restart();
    CR_POS_ERR <= 16'h0004;
    CR_STOP <= 1'b1;
    @(posedge CLK);
    CR_STOP <= 1'b0;
    repeat (2000) @(posedge CLK);
    chk(FAULT, 0);
  endtask : t_settle
  initial begin
    repeat (12) @(posedge CLK);
    t_pf_dem();
    t_follow();
    t_ovc();
    t_settle();
    t_enc();
    wrap_up();
  end
  // watchdog against a hang
  initial begin
    #2_000_000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_top
